// ### design/pcfb_regs.vh
// register map, field positions, reset values and timing constants of the clock fanout
`ifndef PCFB_REGS_VH
`define PCFB_REGS_VH

`define PCFB_ADDR_CTRL        8'h00
`define PCFB_ADDR_STATUS      8'h04

`define PCFB_CTRL_THR_LSB     0
`define PCFB_CTRL_THR_MSB     15
`define PCFB_CTRL_RESET       16'h0010

`define PCFB_STAT_LOCK        0
`define PCFB_STAT_BYPASS      1
`define PCFB_STAT_STATE_LSB   2
`define PCFB_STAT_STATE_MSB   3
`define PCFB_STAT_BANK_LSB    4
`define PCFB_STAT_BANK_MSB    7
`define PCFB_STAT_PER_LSB     16
`define PCFB_STAT_PER_MSB     31

`define PCFB_MCLK_MHZ         125
`define PCFB_STAB_TIME_US     1000
`define PCFB_STAB_CYCLES      (`PCFB_STAB_TIME_US * `PCFB_MCLK_MHZ)

`define PCFB_NCO_LEAD         16'h0004
`define PCFB_PHASE_TOL        16'h0001
`define PCFB_PER_TOL          16'h0001

`endif

// ### design/pcfb_bank.v
// one output bank: enable synchroniser, glitch-free gate and four clock outputs
`default_nettype none

module pcfb_bank #(
  parameter WIDTH = 4
) (
  input  wire             mclk,        // system clock
  input  wire             reset_n,     // async reset, active low
  input  wire             bankEnable,  // bank enable pin, asynchronous
  input  wire             nextClk,     // next value of the shared clock source
  output reg  [WIDTH-1:0] bankOutputs, // gated clock outputs
  output reg              gateOpen     // current state of the bank gate
);

  reg enS1;
  reg enS2;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      enS1        <= 1'b0;
      enS2        <= 1'b0;
      gateOpen    <= 1'b0;
      bankOutputs <= {WIDTH{1'b0}};
    end else begin
      enS1 <= bankEnable;
      enS2 <= enS1;
      // gate moves only in the low phase, so no runt pulse reaches the loads
      if (!nextClk) begin
        gateOpen <= enS2;
      end
      // closed gate holds low, open gate replicates the shared source
      bankOutputs <= {WIDTH{gateOpen & nextClk}};
    end
  end

endmodule // pcfb_bank

`default_nettype wire

// ### design/pcfb_top.v
// clock fanout: reference tracking loop, lock detect, four gated banks, APB status
`default_nettype none
`include "pcfb_regs.vh"

module pcfb_top #(
  parameter PW          = 16,                 // width of period and phase counters
  parameter STAB_CYCLES = `PCFB_STAB_CYCLES   // 1 ms of mclk cycles
) (
  input  wire        mclk,                    // system clock, 125 MHz
  input  wire        reset_n,                 // async reset, active low
  input  wire        referenceClock,          // reference clock pin
  input  wire        feedbackIn,              // feedback input pin
  input  wire        bankOneEnable,           // bank one enable pin
  input  wire        bankTwoEnable,           // bank two enable pin
  input  wire        bankThreeEnable,         // bank three enable pin
  input  wire        bankFourEnable,          // bank four enable pin
  input  wire        analogSupplyBypassStrap, // high selects bypass
  output wire [3:0]  bankOneOutputs,          // bank one clocks
  output wire [3:0]  bankTwoOutputs,          // bank two clocks
  output wire [3:0]  bankThreeOutputs,        // bank three clocks
  output wire [3:0]  bankFourOutputs,         // bank four clocks
  output reg         feedbackOut,             // feedback clock output
  output reg         lockStatus,              // loop locked
  input  wire        psel,                    // apb select
  input  wire        penable,                 // apb enable
  input  wire        pwrite,                  // apb direction
  input  wire [7:0]  paddr,                   // apb byte address
  input  wire [31:0] pwdata,                  // apb write data
  output reg  [31:0] prdata,                  // apb read data
  output reg         pready,                  // apb ready
  output reg         pslverr                  // apb error, unmapped address
);

  localparam [1:0] ST_ACQ   = 2'b00;
  localparam [1:0] ST_TRACK = 2'b01;
  localparam [1:0] ST_LOCK  = 2'b10;

  localparam [31:0] STAB_MAX = STAB_CYCLES;

  reg          refS1, refS2, refPrev;
  reg          fbS1, fbS2, fbPrev;
  reg          bypS1, bypS2;
  reg [1:0]    state;
  reg [PW-1:0] periodCnt;
  reg [PW-1:0] measPeriod;
  reg [PW-1:0] stableCnt;
  reg [PW-1:0] fbAge;
  reg [PW-1:0] phase;
  reg [31:0]   stabTimer;
  reg [15:0]   lockThreshold;
  reg          srcClk;

  wire refRise = refS2 & ~refPrev;
  wire fbRise  = fbS2 & ~fbPrev;
  wire [PW-1:0] newPeriod = periodCnt + {{(PW-1){1'b0}}, 1'b1};
  wire [PW-1:0] perDiff = (newPeriod > measPeriod) ? newPeriod - measPeriod
                                                   : measPeriod - newPeriod;
  wire perStable = (perDiff <= `PCFB_PER_TOL);
  wire phaseOk   = fbRise | (fbAge <= `PCFB_PHASE_TOL);
  wire [PW-1:0] halfPeriod = {1'b0, measPeriod[PW-1:1]};
  wire genHigh   = (phase < halfPeriod);
  wire thrMet    = (stableCnt >= lockThreshold[PW-1:0]);

  reg next_src;
  always @* begin
    if (bypS2) begin
      next_src = refS2;
    end else if (state == ST_ACQ) begin
      next_src = refS2;
    end else begin
      next_src = genHigh;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers and reference measurement
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      refS1      <= 1'b0;
      refS2      <= 1'b0;
      refPrev    <= 1'b0;
      fbS1       <= 1'b0;
      fbS2       <= 1'b0;
      fbPrev     <= 1'b0;
      bypS1      <= 1'b0;
      bypS2      <= 1'b0;
      periodCnt  <= {PW{1'b0}};
      measPeriod <= {PW{1'b0}};
      stableCnt  <= {PW{1'b0}};
      fbAge      <= {PW{1'b1}};
    end else begin
      refS1   <= referenceClock;
      refS2   <= refS1;
      refPrev <= refS2;
      fbS1    <= feedbackIn;
      fbS2    <= fbS1;
      fbPrev  <= fbS2;
      bypS1   <= analogSupplyBypassStrap;
      bypS2   <= bypS1;
      if (fbRise) begin
        fbAge <= {PW{1'b0}};
      end else if (fbAge != {PW{1'b1}}) begin
        fbAge <= fbAge + {{(PW-1){1'b0}}, 1'b1};
      end
      if (refRise) begin
        periodCnt  <= {PW{1'b0}};
        measPeriod <= newPeriod;
        // a change of reference period by more than one mclk cycle restarts the stable count
        if (perStable && stableCnt != {PW{1'b1}}) begin
          stableCnt <= stableCnt + {{(PW-1){1'b0}}, 1'b1};
        end else if (!perStable) begin
          stableCnt <= {PW{1'b0}};
        end
      end else if (periodCnt != {PW{1'b1}}) begin
        periodCnt <= periodCnt + {{(PW-1){1'b0}}, 1'b1};
      end else begin
        stableCnt <= {PW{1'b0}}; // reference stopped
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // acquisition, tracking and lock
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= ST_ACQ;
      stabTimer  <= 32'h0000_0000;
      lockStatus <= 1'b0;
    end else begin
      case (state)
        ST_ACQ: begin
          lockStatus <= 1'b0;
          if (bypS2 || stableCnt == {PW{1'b0}}) begin
            stabTimer <= 32'h0000_0000;
          end else if (stabTimer < STAB_MAX) begin
            stabTimer <= stabTimer + 32'h0000_0001;
          end
          // threshold or the 1 ms bound, whichever first, ends acquisition
          if (!bypS2 && stableCnt != {PW{1'b0}} && (thrMet || stabTimer >= STAB_MAX)) begin
            state <= ST_TRACK;
          end
        end
        ST_TRACK: begin
          lockStatus <= 1'b0;
          if (bypS2 || stableCnt == {PW{1'b0}}) begin
            state <= ST_ACQ;
          end else if (refRise && phaseOk) begin
            state      <= ST_LOCK;
            lockStatus <= 1'b1;
          end
        end
        ST_LOCK: begin
          // loss of period or phase drops the flag at once
          if (bypS2 || stableCnt == {PW{1'b0}} || (refRise && !phaseOk)) begin
            state      <= ST_ACQ;
            stabTimer  <= 32'h0000_0000;
            lockStatus <= 1'b0;
          end
        end
        default: begin
          state      <= ST_ACQ;
          lockStatus <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // phase generator: lead offsets the sync and output latency of the loop
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase       <= {PW{1'b0}};
      srcClk      <= 1'b0;
      feedbackOut <= 1'b0;
    end else begin
      if (refRise) begin
        phase <= `PCFB_NCO_LEAD;
      end else if (phase + {{(PW-1){1'b0}}, 1'b1} >= measPeriod) begin
        phase <= {PW{1'b0}};
      end else begin
        phase <= phase + {{(PW-1){1'b0}}, 1'b1};
      end
      srcClk      <= next_src;
      feedbackOut <= next_src;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output banks
  wire [3:0] bankEn   = {bankFourEnable, bankThreeEnable, bankTwoEnable, bankOneEnable};
  wire [3:0] gateOpen;
  wire [3:0] bankOut [0:3];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gBank
      pcfb_bank #(.WIDTH(4)) uBank (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .bankEnable  (bankEn[gi]),
        .nextClk     (next_src),
        .bankOutputs (bankOut[gi]),
        .gateOpen    (gateOpen[gi])
      );
    end
  endgenerate

  assign bankOneOutputs   = bankOut[0];
  assign bankTwoOutputs   = bankOut[1];
  assign bankThreeOutputs = bankOut[2];
  assign bankFourOutputs  = bankOut[3];

  //////////////////////////////////////////////////////////////////////////
  // apb slave: read data prepared in setup, so access never waits
  wire setup  = psel & ~penable;
  wire access = psel & penable & pready;
  wire mapped = (paddr == `PCFB_ADDR_CTRL) || (paddr == `PCFB_ADDR_STATUS);

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    if (paddr == `PCFB_ADDR_CTRL) begin
      next_rdata[`PCFB_CTRL_THR_MSB:`PCFB_CTRL_THR_LSB] = lockThreshold;
    end else if (paddr == `PCFB_ADDR_STATUS) begin
      next_rdata[`PCFB_STAT_LOCK]   = lockStatus;
      next_rdata[`PCFB_STAT_BYPASS] = bypS2;
      next_rdata[`PCFB_STAT_STATE_MSB:`PCFB_STAT_STATE_LSB] = state;
      next_rdata[`PCFB_STAT_BANK_MSB:`PCFB_STAT_BANK_LSB]   = gateOpen;
      next_rdata[`PCFB_STAT_PER_MSB:`PCFB_STAT_PER_LSB]     = measPeriod[15:0];
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      lockThreshold <= `PCFB_CTRL_RESET;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end
      if (access && pwrite && paddr == `PCFB_ADDR_CTRL) begin
        lockThreshold <= pwdata[`PCFB_CTRL_THR_MSB:`PCFB_CTRL_THR_LSB];
      end
    end
  end

endmodule // pcfb_top

`default_nettype wire

// ### bench/pcfb_properties.sv
// port assertions for the clock fanout
`default_nettype none
module pcfb_props (
  input wire logic       mclk,                    // system clock
  input wire logic       reset_n,                 // async reset, active low
  input wire logic       referenceClock,          // reference pin
  input wire logic       bankOneEnable,           // bank one enable
  input wire logic       analogSupplyBypassStrap, // bypass strap
  input wire logic [3:0] bankOneOutputs,          // bank one clocks
  input wire logic [3:0] bankFourOutputs,         // bank four clocks
  input wire logic       feedbackOut,             // feedback clock
  input wire logic       lockStatus,              // lock flag
  input wire logic       psel,                    // apb select
  input wire logic       penable,                 // apb enable
  input wire logic [7:0] paddr,                   // apb address
  input wire logic       pready,                  // apb ready
  input wire logic       pslverr                  // apb error
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       refSeen;
  logic [7:0] refCnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // reference rises since reset; a lock needs at least one measured stable period
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      refSeen <= 1'b0;
      refCnt  <= 8'h00;
    end else begin
      refSeen <= referenceClock;
      if (referenceClock && !refSeen && refCnt != 8'hff) refCnt <= refCnt + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_replica; (bankOneOutputs == 4'h0 || bankOneOutputs == {4{feedbackOut}}) &&
    (bankFourOutputs == 4'h0 || bankFourOutputs == {4{feedbackOut}}); endproperty
  a_replica: assert property (p_replica) else $error("bank output not a replica");
  property p_gate; $rose(bankOneOutputs[0]) |-> $past(bankOneEnable, 2) ||
    $past(bankOneEnable, 3) || $past(bankOneEnable, 4) || $past(bankOneEnable, 5); endproperty
  a_gate: assert property (p_gate) else $error("disabled bank pulsed");
  property p_no_runt; $past(bankOneOutputs[0]) && $past(feedbackOut) && feedbackOut
    |-> bankOneOutputs[0]; endproperty
  a_no_runt: assert property (p_no_runt) else $error("shortened bank pulse");
  property p_bypass; analogSupplyBypassStrap [*8] |-> feedbackOut == $past(referenceClock, 3);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not passing reference");
  property p_bypass_unlock; analogSupplyBypassStrap [*6] |-> !lockStatus; endproperty
  a_bypass_unlock: assert property (p_bypass_unlock) else $error("lock in bypass");
  property p_lock_wait; $rose(lockStatus) |-> refCnt >= 8'h03; endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("lock came too early");
  property p_duty; $rose(feedbackOut) && lockStatus && !analogSupplyBypassStrap
    |-> feedbackOut [*5] ##1 !feedbackOut; endproperty
  a_duty: assert property (p_duty) else $error("locked duty not half");
  property p_apb_ready; psel && !penable |=> pready; endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");
  property p_apb_err; pready && psel && paddr != 8'h00 && paddr != 8'h04 |-> pslverr;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("unmapped access without error");
endmodule // pcfb_props

bind pcfb_top pcfb_props pcfb_props_i (.mclk(mclk), .reset_n(reset_n),
  .referenceClock(referenceClock), .bankOneEnable(bankOneEnable),
  .analogSupplyBypassStrap(analogSupplyBypassStrap), .bankOneOutputs(bankOneOutputs),
  .bankFourOutputs(bankFourOutputs), .feedbackOut(feedbackOut), .lockStatus(lockStatus),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### bench/pcfb_ref_source.sv
// reference clock source and board feedback wire
`default_nettype none
module pcfb_ref_source (
  input  wire logic       mclk,           // system clock
  input  wire logic [7:0] period,         // reference period in mclk cycles
  input  wire logic [7:0] highTime,       // high cycles of each period
  input  wire logic       feedbackOut,    // from the block
  output var  logic       referenceClock, // to the block
  output wire logic       feedbackIn      // to the block
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] phase = 8'h00;
  initial referenceClock = 1'b0;
  assign feedbackIn = feedbackOut;
  // fixed period and phase; uneven duty on purpose
  always @(posedge mclk) begin
    phase <= (phase + 8'h01 >= period) ? 8'h00 : phase + 8'h01;
    referenceClock <= (phase < highTime);
  end
endmodule // pcfb_ref_source
`default_nettype wire

// ### bench/pll_clock_fanout_banks_test.sv
// self-checking bench for the clock fanout
`default_nettype none
module pll_clock_fanout_banks_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  en = 4'h0;
  logic        strap = 1'b1;
  logic [7:0]  period = 8'h0a;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, referenceClock, feedbackIn, feedbackOut, lockStatus;
  wire logic [15:0] banks;
  logic [3:0]  refHist = 4'h0;
  int          bad_count = 0, checks_done = 0, n, hi;
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) refHist <= {refHist[2:0], referenceClock};
  pcfb_ref_source pcfb_ref_source_i (.mclk(mclk), .period(period), .highTime(period - 8'h03),
    .feedbackOut(feedbackOut), .referenceClock(referenceClock), .feedbackIn(feedbackIn));
  pcfb_top #(.STAB_CYCLES(200)) pcfb_top_i (.mclk(mclk), .reset_n(reset_n),
    .referenceClock(referenceClock), .feedbackIn(feedbackIn), .bankOneEnable(en[0]),
    .bankTwoEnable(en[1]), .bankThreeEnable(en[2]), .bankFourEnable(en[3]),
    .analogSupplyBypassStrap(strap), .bankOneOutputs(banks[3:0]),
    .bankTwoOutputs(banks[7:4]), .bankThreeOutputs(banks[11:8]),
    .bankFourOutputs(banks[15:12]), .feedbackOut(feedbackOut), .lockStatus(lockStatus),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("counts: checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // which 0 watches the lock flag, 1 the feedback clock
  task automatic wait_for(input int which, input logic want, input int limit);
    n = 0;
    while ((which ? feedbackOut : lockStatus) !== want && n < limit) begin
      @(posedge mclk);
      n++;
    end
    if ((which ? feedbackOut : lockStatus) !== want) begin
      bad_count++;
      results();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      results();
    end
  endtask
  // outputs trail the reference pin by three edges on the pass-through path
  task automatic bank_chk(input int cycles);
    repeat (cycles) begin
      @(posedge mclk);
      for (int b = 0; b < 4; b++)
        chk({28'h0, banks[4*b +: 4]}, {28'h0, en[b] ? {4{refHist[2]}} : 4'h0});
      chk({31'h0, feedbackOut}, {31'h0, refHist[2]});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'hffff, 32'h2);
    apb(1'b1, 8'h00, 32'h20);
    apb(1'b1, 8'h04, 32'hffff);
    apb(1'b0, 8'h00, 32'h0);
    chk({rd[30:0], err}, 32'h40);
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test registers done");
    for (int c = 0; c < 16; c++) begin
      en <= c[3:0];
      repeat (24) @(posedge mclk);
      bank_chk(10);
    end
    $display("test bypass_bank_table done");
    strap <= 1'b0;
    wait_for(0, 1'b1, 500);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h000a00f9);
    wait_for(1, 1'b0, 20);
    wait_for(1, 1'b1, 20);
    hi = 0;
    repeat (10) begin
      @(posedge mclk);
      hi += feedbackOut + banks[15];
    end
    chk(32'(hi), 32'ha);
    $display("test lock_and_duty done");
    wait_for(1, 1'b0, 20);
    strap <= 1'b1;
    wait_for(0, 1'b0, 20);
    bank_chk(10);
    $display("test bypass_unlock done");
    results();
  end
endmodule // pll_clock_fanout_banks_test
`default_nettype wire
